// >>> common/bcd_pkg.sv
// constants, opcodes and state codes of the bit and control op decoder
// assumes byte-addressed program counter, 16-bit words at even addresses
package bcd_pkg;
    // ------------------------------------------------------------
    // widths, pc step and reset values
    // ------------------------------------------------------------
    localparam int         PC_W         = 21;
    localparam logic [20:0] PC_STEP     = 21'h000002;
    localparam logic [20:0] PC_RST      = 21'h000000;
    localparam logic       TO_RST       = 1'b1;
    localparam logic       PD_RST       = 1'b1;
    localparam int         PIN_W        = 8;
    // ------------------------------------------------------------
    // top nibble of the instruction word
    // ------------------------------------------------------------
    localparam logic [3:0] OP_CTRL      = 4'h0;
    localparam logic [3:0] OP_BIT_TOG   = 4'h7;
    localparam logic [3:0] OP_BIT_SET   = 4'h8;
    localparam logic [3:0] OP_BIT_CLR   = 4'h9;
    localparam logic [3:0] OP_SKIP_SET  = 4'ha;
    localparam logic [3:0] OP_SKIP_CLR  = 4'hb;
    localparam logic [3:0] OP_MOVE2     = 4'hc;
    localparam logic [3:0] OP_REL       = 4'hd;
    localparam logic [3:0] OP_BR_COND   = 4'he;
    localparam logic [3:0] OP_SECOND    = 4'hf;
    // ------------------------------------------------------------
    // second nibble and whole-word encodings
    // ------------------------------------------------------------
    localparam logic [2:0] SUB_CALL     = 3'h6;
    localparam logic [3:0] SUB_ABSOLUTE_JUMP     = 4'hf;
    localparam logic [3:0] SUB_LOADFSR  = 4'he;
    localparam logic [3:0] SUB_RETLIT   = 4'hc;
    localparam logic [7:0] HI_ZERO      = 8'h00;
    localparam logic [7:0] LO_NOP       = 8'h00;
    localparam logic [7:0] LO_STANDBY   = 8'h03;
    localparam logic [7:0] LO_WDT       = 8'h04;
    localparam logic [7:0] LO_PUSH      = 8'h05;
    localparam logic [7:0] LO_POP       = 8'h06;
    localparam logic [7:0] LO_DAW       = 8'h07;
    localparam logic [7:0] LO_SWRESET   = 8'hff;
    localparam logic [6:0] LO_IRQ_RET   = 7'h08;
    localparam logic [6:0] LO_SUB_RET   = 7'h09;
    // ------------------------------------------------------------
    // branch conditions
    // ------------------------------------------------------------
    localparam logic [2:0] CC_Z         = 3'h0;
    localparam logic [2:0] CC_NZ        = 3'h1;
    localparam logic [2:0] CC_C         = 3'h2;
    localparam logic [2:0] CC_NC        = 3'h3;
    localparam logic [2:0] CC_OV        = 3'h4;
    localparam logic [2:0] CC_NOV       = 3'h5;
    localparam logic [2:0] CC_N         = 3'h6;
    localparam logic [2:0] CC_NN        = 3'h7;

    typedef enum logic [3:0] {
        ST_EXEC  = 4'b0001,
        ST_FLUSH = 4'b0010,
        ST_SKIP  = 4'b0100,
        ST_WORD2 = 4'b1000
    } bcd_state_t;
endpackage

// >>> common/bcd_pin_if.sv
// carrier for pin levels between the decoder and its synchroniser
// assumes the raw side comes from outside the ref_clk domain
`timescale 1ns/1ps
interface bcd_pin_if;
    logic [7:0] raw;
    logic [7:0] synced;
    modport sync_mp (input raw, output synced);
    modport user_mp (output raw, input synced);
endinterface

// >>> core/bcd_sync.sv
// two-flop synchroniser for the port pin levels
// assumes ref_clk is the only clock; first stage feeds only the second
`timescale 1ns/1ps
module bcd_sync (
    input  wire logic   ref_clk, // core clock
    input  wire logic   rst,     // sync reset, high
    bcd_pin_if.sync_mp  pins     // raw in, synced out
);
    logic [7:0] meta_q;
    logic [7:0] sync_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end else begin
            meta_q <= pins.raw;
            sync_q <= meta_q;
        end
    end

    assign pins.synced = sync_q;
endmodule

// >>> core/bcd_decoder.sv
// decoder and sequencer for bit-modify and control-flow instructions
// assumes program memory returns the word at fetch_addr in the same cycle
// and the data path returns the file byte at instr_word[7:0] combinationally
//
// What this block does
// - bit clear/set/toggle; port source is pins
// - bit write to timer zero clears prescaler
// - skip next word when tested bit clear
// - skip next word when tested bit set
// - skip costs one or two extra no-op cycles
// - conditional branch: 1110, condition nibble, offset
// - taken branch adds one flushed cycle
// - relative jump and call take two cycles
// - absolute call: two words, fast-return bit
// - absolute jump: two words, three cycles
// - lone 1111 word or zero word: no-op
// - pop discards return stack top, one cycle
// - push saves next address, one cycle
// - interrupt return re-enables irqs, two cycles
// - literal return loads working register, returns
// - standby and watchdog kick set timeout; standby clears powerdown, kick sets it
`timescale 1ns/1ps
module bcd_decoder
    import bcd_pkg::*;
(
    input  wire logic [15:0]       instr_word,        // word at fetch_addr
    input  wire logic [7:0]        file_latch_data,   // file byte, latch view
    input  wire logic              file_is_port,      // file is a port reg
    input  wire logic              file_is_tmr,       // file is timer count
    input  wire logic              prescaler_assigned,// prescaler on timer
    input  wire logic [7:0]        port_pins,         // raw pin levels
    input  wire logic              flag_zero,         // status zero
    input  wire logic              flag_carry,        // status carry
    input  wire logic              flag_overflow,     // status overflow
    input  wire logic              flag_negative,     // status negative
    input  wire logic [bcd_pkg::PC_W-1:0] return_stack_top, // stack top
    input  wire logic              ref_clk,           // core clock
    input  wire logic              rst,               // sync reset, high
    output logic [bcd_pkg::PC_W-1:0] fetch_addr,      // program counter
    output logic                   nop_cycle,         // cycle is a no-op
    output logic                   file_wr_en,        // file write strobe
    output logic [7:0]             file_wr_addr,      // file address
    output logic                   file_wr_access,    // access-bank flag
    output logic [7:0]             file_wr_data,      // byte to write
    output logic                   prescaler_clr,     // clear prescaler
    output logic                   stack_push,        // push strobe
    output logic [bcd_pkg::PC_W-1:0] stack_push_data, // pushed address
    output logic                   stack_pop,         // pop strobe
    output logic                   fast_save,         // save shadow regs
    output logic                   fast_restore,      // restore shadows
    output logic                   working_register_load,         // working reg write
    output logic [7:0]             working_register_data,         // working reg value
    output logic                   irq_reenable,      // set irq enables
    output logic                   daw_req,           // decimal adjust
    output logic                   standby_req,       // enter standby
    output logic                   wdt_clear,         // watchdog kick
    output logic                   sw_reset,          // software reset
    output logic                   timeout_flag,      // status timeout
    output logic                   powerdown_flag     // status powerdown
);
    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    bcd_pin_if pin_bus ();
    assign pin_bus.raw = port_pins;

    bcd_sync u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pins    (pin_bus.sync_mp)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bcd_state_t        state_q, state_d;
    logic [PC_W-1:0]   pc_q, pc_d;
    logic [7:0]        lo_q, lo_d;
    logic              call_q, call_d;
    logic              fast_q, fast_d;

    logic              wr_en_d, presc_d, push_d, pop_d, fsave_d, frest_d;
    logic              wload_d, irq_d, daw_d, stby_d, wdt_d, swr_d;
    logic [7:0]        wr_data_d, wdata_d;
    logic [PC_W-1:0]   push_data_d;
    logic              to_q, to_d, pd_q, pd_d;

    logic [3:0]        op;
    logic [7:0]        src_byte;
    logic              src_bit;
    logic              cond_true;
    logic [PC_W-1:0]   pc_next;
    logic [PC_W-1:0]   off8;
    logic [PC_W-1:0]   off11;

    assign op    = instr_word[15:12];
    assign pc_next = pc_q + PC_STEP;
    assign off8  = {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
    assign off11 = {{9{instr_word[10]}}, instr_word[10:0], 1'b0};
    // port reads see the pins so external drivers win over the latch
    assign src_byte = file_is_port ? pin_bus.synced : file_latch_data;
    assign src_bit  = src_byte[instr_word[11:9]];

    // first word of any two-word instruction, for skip length
    function automatic logic two_word_first(input logic [15:0] w);
        logic hit;
        hit = 1'b0;
        if (w[15:12] == OP_MOVE2) begin
            hit = 1'b1;
        end
        if (w[15:12] == OP_BR_COND) begin
            if (w[11:9] == SUB_CALL || w[11:8] == SUB_ABSOLUTE_JUMP
                || w[11:8] == SUB_LOADFSR) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    always_comb begin
        case (instr_word[10:8])
            CC_Z:    cond_true = flag_zero;
            CC_NZ:   cond_true = !flag_zero;
            CC_C:    cond_true = flag_carry;
            CC_NC:   cond_true = !flag_carry;
            CC_OV:   cond_true = flag_overflow;
            CC_NOV:  cond_true = !flag_overflow;
            CC_N:    cond_true = flag_negative;
            CC_NN:   cond_true = !flag_negative;
            default: cond_true = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // decode and sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        pc_d        = pc_next;
        lo_d        = lo_q;
        call_d      = call_q;
        fast_d      = fast_q;
        wr_en_d     = 1'b0;
        wr_data_d   = src_byte;
        presc_d     = 1'b0;
        push_d      = 1'b0;
        push_data_d = pc_next;
        pop_d       = 1'b0;
        fsave_d     = 1'b0;
        frest_d     = 1'b0;
        wload_d     = 1'b0;
        wdata_d     = instr_word[7:0];
        irq_d       = 1'b0;
        daw_d       = 1'b0;
        stby_d      = 1'b0;
        wdt_d       = 1'b0;
        swr_d       = 1'b0;
        to_d        = to_q;
        pd_d        = pd_q;
        case (state_q)
            ST_EXEC: begin
                case (op)
                    OP_BIT_CLR, OP_BIT_SET, OP_BIT_TOG: begin
                        wr_en_d = 1'b1;
                        if (op == OP_BIT_CLR) begin
                            wr_data_d[instr_word[11:9]] = 1'b0;
                        end else if (op == OP_BIT_SET) begin
                            wr_data_d[instr_word[11:9]] = 1'b1;
                        end else begin
                            wr_data_d[instr_word[11:9]] = !src_bit;
                        end
                        presc_d = file_is_tmr && prescaler_assigned;
                    end
                    OP_SKIP_CLR: begin
                        if (!src_bit) begin
                            state_d = ST_SKIP;
                        end
                    end
                    OP_SKIP_SET: begin
                        if (src_bit) begin
                            state_d = ST_SKIP;
                        end
                    end
                    OP_REL: begin
                        pc_d    = pc_next + off11;
                        state_d = ST_FLUSH;
                        push_d  = instr_word[11];
                    end
                    OP_BR_COND: begin
                        if (!instr_word[11]) begin
                            if (cond_true) begin
                                pc_d    = pc_next + off8;
                                state_d = ST_FLUSH;
                            end
                        end else if (instr_word[11:9] == SUB_CALL) begin
                            lo_d    = instr_word[7:0];
                            fast_d  = instr_word[8];
                            call_d  = 1'b1;
                            state_d = ST_WORD2;
                        end else if (instr_word[11:8] == SUB_ABSOLUTE_JUMP) begin
                            lo_d    = instr_word[7:0];
                            fast_d  = 1'b0;
                            call_d  = 1'b0;
                            state_d = ST_WORD2;
                        end
                    end
                    OP_CTRL: begin
                        if (instr_word[11:8] == SUB_RETLIT) begin
                            wload_d = 1'b1;
                            pc_d    = return_stack_top;
                            pop_d   = 1'b1;
                            state_d = ST_FLUSH;
                        end else if (instr_word[11:8] == 4'h0
                                     && instr_word[7:0] != LO_SWRESET) begin
                            if (instr_word[7:1] == LO_IRQ_RET) begin
                                irq_d   = 1'b1;
                                frest_d = instr_word[0];
                                pc_d    = return_stack_top;
                                pop_d   = 1'b1;
                                state_d = ST_FLUSH;
                            end else if (instr_word[7:1]
                                         == LO_SUB_RET) begin
                                frest_d = instr_word[0];
                                pc_d    = return_stack_top;
                                pop_d   = 1'b1;
                                state_d = ST_FLUSH;
                            end else if (instr_word[7:0] == LO_STANDBY) begin
                                stby_d = 1'b1;
                                to_d   = 1'b1;
                                pd_d   = 1'b0;
                            end else if (instr_word[7:0] == LO_WDT) begin
                                wdt_d = 1'b1;
                                to_d  = 1'b1;
                                pd_d  = 1'b1;
                            end else if (instr_word[7:0] == LO_PUSH) begin
                                push_d = 1'b1;
                            end else if (instr_word[7:0] == LO_POP) begin
                                pop_d = 1'b1;
                            end else if (instr_word[7:0] == LO_DAW) begin
                                daw_d = 1'b1;
                            end
                        end else if (instr_word[11:8] == 4'h0
                                     && instr_word[7:0] == LO_SWRESET) begin
                            swr_d   = 1'b1;
                            pc_d    = PC_RST;
                            to_d    = TO_RST;
                            pd_d    = PD_RST;
                            state_d = ST_FLUSH;
                        end
                    end
                    // lone second words and the unused opcodes fall through
                    OP_SECOND: state_d = ST_EXEC;
                    default:   state_d = ST_EXEC;
                endcase
            end
            ST_WORD2: begin
                // second word carries the upper twelve address bits
                pc_d    = {instr_word[11:0], lo_q, 1'b0};
                push_d  = call_q;
                fsave_d = call_q && fast_q;
                state_d = ST_FLUSH;
            end
            ST_SKIP: begin
                // skipped word is a no-op; a two-word one costs one more
                state_d = two_word_first(instr_word) ? ST_SKIP
                                                     : ST_EXEC;
            end
            ST_FLUSH: begin
                pc_d    = pc_q;
                state_d = ST_EXEC;
            end
            default: begin
                pc_d    = pc_q;
                state_d = ST_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_EXEC;
            pc_q    <= PC_RST;
            lo_q    <= 8'h00;
            call_q  <= 1'b0;
            fast_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q    <= pc_d;
            lo_q    <= lo_d;
            call_q  <= call_d;
            fast_q  <= fast_d;
        end
    end

    // ------------------------------------------------------------
    // file write path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            file_wr_en     <= 1'b0;
            file_wr_addr   <= 8'h00;
            file_wr_access <= 1'b0;
            file_wr_data   <= 8'h00;
            prescaler_clr  <= 1'b0;
        end else begin
            file_wr_en     <= wr_en_d;
            file_wr_addr   <= instr_word[7:0];
            file_wr_access <= instr_word[8];
            file_wr_data   <= wr_data_d;
            prescaler_clr  <= presc_d;
        end
    end

    // ------------------------------------------------------------
    // return stack and context
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stack_push      <= 1'b0;
            stack_push_data <= PC_RST;
            stack_pop       <= 1'b0;
            fast_save       <= 1'b0;
            fast_restore    <= 1'b0;
            working_register_load       <= 1'b0;
            working_register_data       <= 8'h00;
            irq_reenable    <= 1'b0;
        end else begin
            stack_push      <= push_d;
            stack_push_data <= push_data_d;
            stack_pop       <= pop_d;
            fast_save       <= fsave_d;
            fast_restore    <= frest_d;
            working_register_load       <= wload_d;
            working_register_data       <= wdata_d;
            irq_reenable    <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // decimal adjust, power, watchdog and reset requests
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            daw_req        <= 1'b0;
            standby_req    <= 1'b0;
            wdt_clear      <= 1'b0;
            sw_reset       <= 1'b0;
            timeout_flag   <= TO_RST;
            powerdown_flag <= PD_RST;
            to_q           <= TO_RST;
            pd_q           <= PD_RST;
        end else begin
            daw_req        <= daw_d;
            standby_req    <= stby_d;
            wdt_clear      <= wdt_d;
            sw_reset       <= swr_d;
            timeout_flag   <= to_d;
            powerdown_flag <= pd_d;
            to_q           <= to_d;
            pd_q           <= pd_d;
        end
    end

    // ------------------------------------------------------------
    // visible pipeline state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nop_cycle <= 1'b0;
        end else begin
            nop_cycle <= (state_d != ST_EXEC);
        end
    end

    assign fetch_addr = pc_q;
endmodule

// >>> test/bcd_pmem.sv
// program memory model for the decoder's fetch side
// assumes the bench loads mem while the decoder is held in reset
`timescale 1ns/1ps
module bcd_pmem (
    input  wire logic [20:0] fetch_addr, // byte address
    output logic      [15:0] instr_word  // word at that address
);
    logic [15:0] mem [0:127];
    // reads at byte address 256 and above give a moving pattern, never a stale word
    assign instr_word = (|fetch_addr[20:8]) ? ~fetch_addr[15:0]
                                             : mem[fetch_addr[7:1]];
endmodule

// >>> test/bcd_decoder_monitor.sv
// assertions on the decoder top ports
// assumes bound into bcd_decoder; port files not modelled
`timescale 1ns/1ps
module bcd_decoder_monitor
    import bcd_pkg::*;
(
    input wire logic [15:0] instr_word,         // word
    input wire logic [7:0]  file_latch_data,    // file byte
    input wire logic        file_is_port,       // port file
    input wire logic        file_is_tmr,        // timer file
    input wire logic        prescaler_assigned, // prescaler on timer
    input wire logic        flag_zero,          // z
    input wire logic        flag_carry,         // c
    input wire logic        flag_overflow,      // ov
    input wire logic        flag_negative,      // n
    input wire logic        ref_clk,            // clock
    input wire logic        rst,                // reset
    input wire logic [20:0] fetch_addr,         // pc
    input wire logic        nop_cycle,          // no-op cycle
    input wire logic        file_wr_en,         // write strobe
    input wire logic [7:0]  file_wr_data,       // write byte
    input wire logic        prescaler_clr,      // prescaler clear
    input wire logic        stack_push,         // push strobe
    input wire logic [20:0] stack_push_data     // pushed address
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire [3:0]  top   = instr_word[15:12];
    wire        ex    = !nop_cycle;
    wire        bit_v = file_latch_data[instr_word[11:9]];
    wire [3:0]  fl    = {flag_negative, flag_overflow, flag_carry, flag_zero};
    wire        tk    = fl[instr_word[10:9]] ^ instr_word[8];
    wire [20:0] boff  = {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
    wire [20:0] joff  = {{9{instr_word[10]}}, instr_word[10:0], 1'b0};
    wire [7:0]  one_b = 8'h01 << instr_word[11:9];
    a_bit_set_src: assert property (ex && top == OP_BIT_SET
        && !file_is_port |=> file_wr_en && file_wr_data ==
        ($past(file_latch_data) | $past(one_b))) else $error("bad set");
    a_tmr_presc_clr: assert property (ex && file_is_tmr
        && prescaler_assigned && top inside {4'h7, 4'h8, 4'h9}
        |=> prescaler_clr) else $error("prescaler not cleared");
    a_skip_if_clr: assert property (ex && top == OP_SKIP_CLR
        && !file_is_port |=> nop_cycle == !$past(bit_v))
        else $error("bad skip on clear");
    a_skip_if_set: assert property (ex && top == OP_SKIP_SET
        && !file_is_port |=> nop_cycle == $past(bit_v))
        else $error("bad skip on set");
    a_cond_branch: assert property (ex && instr_word[15:11] == 5'h1c
        |=> nop_cycle == $past(tk) && fetch_addr == $past(fetch_addr)
        + 21'h2 + ($past(tk) ? $past(boff) : 21'h0)) else $error("bad branch");
    a_rel_jump_pc: assert property (ex && instr_word[15:11] == 5'h1a
        |=> nop_cycle && fetch_addr == $past(fetch_addr) + 21'h2 + $past(joff))
        else $error("bad relative jump");
    a_push_next: assert property (ex && instr_word == 16'h0005
        |=> stack_push && !nop_cycle && stack_push_data ==
        $past(fetch_addr) + 21'h2) else $error("bad push");
    a_lone_word_nop: assert property (ex && top == OP_SECOND
        |=> !file_wr_en && !stack_push && !nop_cycle && fetch_addr ==
        $past(fetch_addr) + 21'h2) else $error("lone word not a no-op");
endmodule
bind bcd_decoder bcd_decoder_monitor bcd_decoder_monitor_inst (.*);

// >>> test/bcd_decoder_tb_top.sv
// bench for the decoder: programs in memory, expected pulses in a queue
// assumes the bcd_pmem model and the bound monitor
`timescale 1ns/1ps
module bcd_decoder_tb_top;
    import bcd_pkg::*;
    logic        ref_clk = 0, rst = 1, file_is_port = 0, file_is_tmr = 0;
    logic        prescaler_assigned = 0, flag_zero = 0, flag_carry = 0;
    logic        flag_overflow = 0, flag_negative = 0, nop_cycle, file_wr_en;
    logic        file_wr_access, prescaler_clr, stack_push, stack_pop;
    logic        fast_save, fast_restore, working_register_load, irq_reenable, daw_req;
    logic        standby_req, wdt_clear, sw_reset, timeout_flag;
    logic        powerdown_flag;
    logic [15:0] instr_word;
    logic [7:0]  file_latch_data = 0, port_pins = 0, lt, pn;
    logic [7:0]  file_wr_addr, file_wr_data, working_register_data;
    logic [20:0] return_stack_top = 0, fetch_addr, stack_push_data;
    logic [3:0]  fl;
    logic [32:0] q[$];
    int          n_fail = 0, cmp_count = 0;
    // per pulse cycle: strobes fired, then payload
    wire  [32:0] obs = {file_wr_en, prescaler_clr, stack_push, fast_save,
        stack_pop, fast_restore, working_register_load, irq_reenable, daw_req,
        standby_req, wdt_clear, sw_reset, file_wr_en ? {4'h0, file_wr_access,
        file_wr_addr, file_wr_data} : stack_push ? stack_push_data :
        working_register_load ? {13'h0, working_register_data} : standby_req | wdt_clear ?
        {19'h0, timeout_flag, powerdown_flag} : 21'h0};
    bcd_decoder bcd_decoder_inst (.*);
    bcd_pmem bcd_pmem_inst (.*);
    always #2 ref_clk = ~ref_clk;
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic ex(input logic [11:0] p, input logic [20:0] d);
        q.push_back({p, d});
    endtask
    task automatic ld(input int a, input logic [15:0] w[$]);
        foreach (w[i]) bcd_pmem_inst.mem[a / 2 + i] = w[i];
    endtask
    task automatic setup(input logic p, input logic t);
        logic [31:0] r;
        r = $urandom;
        lt = r[7:0] & 8'hfe | 8'h10;
        pn = r[15:8];
        fl = r[19:16];
        file_latch_data <= lt;
        port_pins <= pn;
        {flag_negative, flag_overflow, flag_carry, flag_zero} <= fl;
        file_is_port <= p;
        file_is_tmr <= t;
        prescaler_assigned <= t;
        for (int i = 0; i < 128; i++) bcd_pmem_inst.mem[i] = 16'h0;
    endtask
    task automatic run(input int id, input logic [20:0] pc);
        @(posedge ref_clk);
        rst <= 1'b0;
        repeat (60) @(posedge ref_clk);
        check({12'h0, fetch_addr}, {12'h0, pc});
        check(33'(q.size()), 33'h0);
        $display("test %0d done", id);
        rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        if (sw_reset) flag_zero <= 1'b1;
        if (!rst && |obs[32:21])
            check(obs, q.size() ? q.pop_front() : 33'h0);
    end
    initial begin
        repeat (1500) @(posedge ref_clk);
        n_fail++;
        print_verdict;
    end
    initial begin
        void'($urandom(24199));
        repeat (11) @(posedge ref_clk);
        // leading no-ops give the pin synchroniser time after reset
        setup(1'b1, 1'b0);
        ld(6, '{16'h8633, 16'h7b55, 16'h9077, 16'hd7ff});
        ex(12'h800, {5'h0, 8'h33, pn | 8'h08});
        ex(12'h800, {5'h1, 8'h55, pn ^ 8'h20});
        ex(12'h800, {5'h0, 8'h77, pn & 8'hfe});
        run(1, 21'h0c);
        setup(1'b0, 1'b1);
        ld(0, '{16'h9400, 16'hb000, 16'h8200, 16'ha800, 16'hef00, 16'hf000,
            16'hf123, 16'ha000, 16'h7800, 16'hd7ff});
        ex(12'hc00, {13'h0, lt & 8'hfb});
        ex(12'hc00, {13'h0, lt ^ 8'h10});
        run(2, 21'h12);
        setup(1'b0, 1'b0);
        return_stack_top <= 21'h60;
        for (int c = 0; c < 8; c++) begin
            ld(4 * c, '{16'he001 | 16'(c << 8), 16'h8000 | 16'(c)});
            if (!(fl[c >> 1] ^ c[0]))
                ex(12'h800, {5'h0, 8'(c), lt | 8'h01});
        end
        ld(32, '{16'h0005, 16'h0006, 16'hed20, 16'hf000});
        ld(64, '{16'h0cc5});
        ld(96, '{16'h0003, 16'h0004, 16'h0007, 16'hd801, 16'h0, 16'hd7ff});
        ex(12'h200, 21'h22);
        ex(12'h080, 21'h0);
        ex(12'h300, 21'h28);
        ex(12'h0a0, 21'hc5);
        ex(12'h004, 21'h2);
        ex(12'h002, 21'h3);
        ex(12'h008, 21'h0);
        ex(12'h200, 21'h68);
        run(3, 21'h6a);
        setup(1'b0, 1'b0);
        return_stack_top <= 21'h08;
        ld(0, '{16'he007, 16'h0011, 16'h0, 16'h0, 16'h00ff, 16'h0, 16'h0,
            16'h0, 16'hd7ff});
        ex(12'h0d0, 21'h0);
        ex(12'h001, 21'h0);
        @(posedge ref_clk);
        flag_zero <= 1'b0;
        run(4, 21'h10);
        print_verdict;
    end
endmodule
